/* mesm_consts.svh */
// Constants of the metering engine sample map and status block.
// Assumes inclusion by bare name; holds definitions only.
`ifndef MESM_CONSTS_SVH
`define MESM_CONSTS_SVH

// Engine word addresses seen by the host
`define MESM_ADDR_CFG 8'h20
`define MESM_ADDR_SAG_THRESHOLD 8'h24
`define MESM_ADDR_STATUS 8'h80
`define MESM_ADDR_RAW0 8'h00
`define MESM_ADDR_RAW1 8'h01
`define MESM_ADDR_RAW2 8'h02
`define MESM_ADDR_RAW3 8'h03
`define MESM_ADDR_RAW9 8'h09
`define MESM_ADDR_RAW10 8'h0a

// Raw sample slot indices inside the block
`define MESM_SLOT_IA 3'h0
`define MESM_SLOT_IAN 3'h1
`define MESM_SLOT_IB 3'h2
`define MESM_SLOT_IBN 3'h3
`define MESM_SLOT_VB 3'h4
`define MESM_SLOT_VA 3'h5
`define MESM_SLOT_NONE 3'h7

// Input selector handles of the front end
`define MESM_HANDLE_IAP 4'h0
`define MESM_HANDLE_IAN 4'h1
`define MESM_HANDLE_IBP 4'h2
`define MESM_HANDLE_IBN 4'h3
`define MESM_HANDLE_VB 4'h9
`define MESM_HANDLE_VA 4'ha

// Configuration word fields and reset values
`define MESM_CFG_SAG_SAMPLE_COUNT_LSB 8
`define MESM_CFG_SAG_SAMPLE_COUNT_MSB 19
`define MESM_CFG_SAG_PULSE_BIT 20
`define MESM_CFG_ZERO_CROSS_PHASE_SELECT_LSB 6
`define MESM_CFG_RESET_LOCAL 32'h0030db00
`define MESM_CFG_RESET_REMOTE 32'h00b0db00
`define MESM_SAG_THRESHOLD_RESET 32'h00000000

// Status word fields
`define MESM_ST_SAG_A_BIT 0
`define MESM_ST_SAG_B_BIT 1
`define MESM_ST_F0_BIT 3

// Timing: sample rate in millihertz and the clock rate in hertz
`define MESM_CLK_HZ 64'd250000000
`define MESM_PASS_RATE_MHZ 64'd2520620
`define MESM_PASS_CYCLES ((`MESM_CLK_HZ * 64'd1000) / `MESM_PASS_RATE_MHZ)

`endif

/* mesm_pkg.sv */
// Types shared by the metering engine sample map block.
// Assumes mesm_consts.svh is on the include path.
package mesm_pkg;

    typedef logic [3:0] mesm_handle_t;

    typedef struct packed {
        logic [5:0][31:0] raw;
        logic [31:0] cfg;
        logic [31:0] thr;
        logic [31:0] status;
        logic [1:0][11:0] sag_sample_count;
        logic [1:0] sag;
        logic [31:0] pass_cnt;
        logic pass_done;
        logic [31:0] rdata;
        logic aux;
        mesm_handle_t ib_handle;
        logic ib_handle_ok;
    } mesm_state_s;

endpackage

/* mesm_fifo.sv */
// Sample FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module mesm_fifo #(
    parameter int WIDTH = 37,
    parameter int DEPTH = 32
) (
    input wire logic clk, // Clock
    input wire logic rstn, // Async reset, active low
    input wire logic in_valid, // Source offers a word
    output logic in_ready, // Room for a word, registered
    input wire logic [WIDTH-1:0] in_data, // Word from source
    output logic out_valid, // A word is waiting
    input wire logic out_ready, // Sink takes the word
    output logic [WIDTH-1:0] out_data // Oldest word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
        logic not_full;
    } mesm_fifo_s;

    mesm_fifo_s st_r;
    mesm_fifo_s st_nxt;
    logic push;
    logic pop;

    assign push = in_valid && st_r.not_full;
    assign pop = out_ready && (st_r.count != '0);

    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wptr] = in_data;
            st_nxt.wptr = st_r.wptr + 1'b1;
        end
        if (pop)
        begin
            st_nxt.rptr = st_r.rptr + 1'b1;
        end
        st_nxt.count = st_r.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        st_nxt.not_full = (st_nxt.count != DEPTH[AW:0]);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r <= '0;
            st_r.not_full <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign in_ready = st_r.not_full;
    assign out_valid = (st_r.count != '0);
    assign out_data = st_r.mem[st_r.rptr];

    a_fifo_bound: assert property (@(posedge clk) disable iff (!rstn)
        st_r.count <= DEPTH[AW:0])
        else $error("fifo count beyond depth");
endmodule
`default_nettype wire

/* mesm_engine.sv */
// Engine sample placement, status word and configuration word.
// Assumes the front end delivers samples on clk and the host reads the
// shared engine memory through the word port below.
//
// What this block does
// - Raw front-end samples are readable at engine words 0 to 3, 9 and 10.
// - With channel A differential on, the A pins form one input, handle 0, stored at word 0.
// - With remote off and channel B differential on, B is one input, handle 2, at word 2, word 3 untouched.
// - With remote on, remote samples go to word 2, word 3 is untouched and the B handle is undefined.
// - Voltage A uses handle 10 and word 10, voltage B handle 9 and word 9, with no configuration.
// - The status word sits at 0x80 and shows the flags of the pass just finished.
// - Status bits 31 to 4 and bit 2 always read zero.
// - Status bit 3 is a square wave at the fundamental frequency of the measured input.
// - Status bit 0 sets after voltage A stays below threshold for the sag count and holds until it rises above.
// - Status bit 1 does the same for voltage B.
// - A pass-done pulse is raised at 2520.6 Hz so the host can read the status each pass.
// - The configuration word resets to 0x0030DB00 for local sensors or 0x00B0DB00 for remote ones.
// - Configuration bits 19 to 8 give the consecutive low samples that declare a sag, 219 by default.
// - With configuration bit 20 set, the auxiliary pulse output is active while a sag is detected.
`timescale 1ns/10ps
`default_nettype none
`include "mesm_consts.svh"
module mesm_engine #(
    parameter bit REMOTE_CODE = 1'b0,
    parameter int PASS_CYCLES = int'(`MESM_PASS_CYCLES),
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk, // 250 MHz clock
    input wire logic rstn, // Async reset, active low
    input wire logic diff_chan_a_enable, // Channel A differential mode
    input wire logic diff_chan_b_enable, // Channel B differential mode
    input wire logic remote_sensor_enable, // Channel B from remote sensor
    input wire logic sample_valid, // Front end offers a sample
    output logic sample_ready, // Room in the FIFO for a sample, registered
    input wire logic [3:0] sample_handle, // Selector handle of the sample
    input wire logic sample_remote, // Sample came over the remote link
    input wire logic [31:0] sample_data, // Signed sample value
    input wire logic [7:0] host_addr, // Engine word address
    input wire logic host_wr, // Word write strobe
    input wire logic host_rd, // Word read strobe
    input wire logic [31:0] host_wdata, // Write data
    output logic [31:0] host_rdata_r, // Read data, one cycle after host_rd
    output logic pass_done_r, // One-cycle pulse at end of each pass
    output logic aux_pulse_output_r, // Sag alarm output
    output logic [3:0] input_selector_handle_r, // Handle in use for channel B
    output logic input_selector_handle_ok_r // Low when the B handle is undefined
);
    localparam int FW = 37;

    mesm_pkg::mesm_state_s st_r;
    mesm_pkg::mesm_state_s st_nxt;
    logic fifo_valid;
    logic fifo_ready;
    logic [FW-1:0] fifo_data;
    logic [3:0] pop_handle;
    logic pop_remote;
    logic [31:0] pop_value;
    logic pass_end;
    logic host_on_raw;
    logic drain;
    logic [2:0] slot;

    function automatic logic [31:0] mag(input logic [31:0] v);
        mag = v[31] ? (~v + 32'h00000001) : v;
    endfunction

    // Where a sample lands; SLOT_NONE leaves every word untouched
    function automatic logic [2:0] place(input logic [3:0] h, input logic rem, input logic da,
                                         input logic db, input logic re);
        place = `MESM_SLOT_NONE;
        if (rem)
        begin
            if (re)
            begin
                place = `MESM_SLOT_IB;
            end
        end
        else
        begin
            unique case (h)
                `MESM_HANDLE_IAP: place = `MESM_SLOT_IA;
                `MESM_HANDLE_IAN: place = da ? `MESM_SLOT_NONE : `MESM_SLOT_IAN;
                `MESM_HANDLE_IBP: place = re ? `MESM_SLOT_NONE : `MESM_SLOT_IB;
                `MESM_HANDLE_IBN: place = (re || db) ? `MESM_SLOT_NONE : `MESM_SLOT_IBN;
                `MESM_HANDLE_VB: place = `MESM_SLOT_VB;
                `MESM_HANDLE_VA: place = `MESM_SLOT_VA;
                default: place = `MESM_SLOT_NONE;
            endcase
        end
    endfunction

    mesm_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data({sample_handle, sample_remote, sample_data}),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    assign pop_handle = fifo_data[36:33];
    assign pop_remote = fifo_data[32];
    assign pop_value = fifo_data[31:0];
    assign pass_end = (st_r.pass_cnt == 32'(PASS_CYCLES - 1));
    // Host has priority on the shared raw words; the engine waits for as many cycles as the host strobe stays on them
    assign host_on_raw = (host_rd || host_wr) && (host_addr <= `MESM_ADDR_RAW10);
    // No sample is written in the pass-end cycle so all flags see one set of samples
    assign fifo_ready = !pass_end && !host_on_raw;
    assign drain = fifo_valid && fifo_ready;
    assign slot = place(pop_handle, pop_remote, diff_chan_a_enable, diff_chan_b_enable, remote_sensor_enable);

    always_comb
    begin
        logic [11:0] need;
        logic [31:0] v;
        logic [31:0] word;
        logic sel_b;
        need = 12'h000;
        v = 32'h00000000;
        word = 32'h00000000;
        sel_b = 1'b0;
        st_nxt = st_r;
        st_nxt.pass_done = 1'b0;

        // Sample placement
        if (drain && (slot != `MESM_SLOT_NONE))
        begin
            st_nxt.raw[slot] = pop_value;
        end

        // Channel B handle follows the mode bits
        st_nxt.ib_handle_ok = !remote_sensor_enable;
        st_nxt.ib_handle = diff_chan_b_enable ? `MESM_HANDLE_IBP : `MESM_HANDLE_IBN;
        if (remote_sensor_enable)
        begin
            st_nxt.ib_handle = `MESM_HANDLE_IBP;
        end

        // Host writes; raw and status words are read only
        if (host_wr && (host_addr == `MESM_ADDR_CFG))
        begin
            st_nxt.cfg = host_wdata;
        end
        if (host_wr && (host_addr == `MESM_ADDR_SAG_THRESHOLD))
        begin
            st_nxt.thr = host_wdata;
        end

        // Pass timing
        st_nxt.pass_cnt = pass_end ? 32'h00000000 : st_r.pass_cnt + 32'h00000001;
        if (pass_end)
        begin
            need = st_r.cfg[`MESM_CFG_SAG_SAMPLE_COUNT_MSB:`MESM_CFG_SAG_SAMPLE_COUNT_LSB];
            if (need == 12'h000)
            begin
                need = 12'h001;
            end
            for (int p = 0; p < 2; p++)
            begin
                v = mag(st_r.raw[p == 0 ? `MESM_SLOT_VA : `MESM_SLOT_VB]);
                if (v < st_r.thr)
                begin
                    if (st_r.sag_sample_count[p] != 12'hfff)
                    begin
                        st_nxt.sag_sample_count[p] = st_r.sag_sample_count[p] + 12'h001;
                    end
                    if (st_r.sag_sample_count[p] + 12'h001 >= need)
                    begin
                        st_nxt.sag[p] = 1'b1;
                    end
                end
                else
                begin
                    st_nxt.sag_sample_count[p] = 12'h000;
                    if (v > st_r.thr)
                    begin
                        st_nxt.sag[p] = 1'b0;
                    end
                end
            end
            // Sign of the selected voltage: high on positive half cycles
            sel_b = st_r.cfg[`MESM_CFG_ZERO_CROSS_PHASE_SELECT_LSB];
            word = 32'h00000000;
            word[`MESM_ST_SAG_A_BIT] = st_nxt.sag[0];
            word[`MESM_ST_SAG_B_BIT] = st_nxt.sag[1];
            word[`MESM_ST_F0_BIT] = !st_r.raw[sel_b ? `MESM_SLOT_VB : `MESM_SLOT_VA][31];
            st_nxt.status = word;
            st_nxt.pass_done = 1'b1;
        end

        st_nxt.aux = st_r.cfg[`MESM_CFG_SAG_PULSE_BIT] && (st_r.sag != 2'b00);

        // Read port: registered answer, unmapped words read zero
        if (host_rd)
        begin
            unique case (host_addr)
                `MESM_ADDR_RAW0: st_nxt.rdata = st_r.raw[`MESM_SLOT_IA];
                `MESM_ADDR_RAW1: st_nxt.rdata = st_r.raw[`MESM_SLOT_IAN];
                `MESM_ADDR_RAW2: st_nxt.rdata = st_r.raw[`MESM_SLOT_IB];
                `MESM_ADDR_RAW3: st_nxt.rdata = st_r.raw[`MESM_SLOT_IBN];
                `MESM_ADDR_RAW9: st_nxt.rdata = st_r.raw[`MESM_SLOT_VB];
                `MESM_ADDR_RAW10: st_nxt.rdata = st_r.raw[`MESM_SLOT_VA];
                `MESM_ADDR_CFG: st_nxt.rdata = st_r.cfg;
                `MESM_ADDR_SAG_THRESHOLD: st_nxt.rdata = st_r.thr;
                `MESM_ADDR_STATUS: st_nxt.rdata = st_r.status;
                default: st_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r <= '0;
            st_r.cfg <= REMOTE_CODE ? `MESM_CFG_RESET_REMOTE : `MESM_CFG_RESET_LOCAL;
            st_r.thr <= `MESM_SAG_THRESHOLD_RESET;
            st_r.ib_handle <= `MESM_HANDLE_IBN;
            st_r.ib_handle_ok <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign host_rdata_r = st_r.rdata;
    assign pass_done_r = st_r.pass_done;
    assign aux_pulse_output_r = st_r.aux;
    assign input_selector_handle_r = st_r.ib_handle;
    assign input_selector_handle_ok_r = st_r.ib_handle_ok;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_cfg_write;
        host_wr && (host_addr == `MESM_ADDR_CFG);
    endsequence

    sequence s_pop_to(logic [2:0] s);
        drain && (slot == s);
    endsequence

    sequence s_drop_b_neg;
        drain && !pop_remote && (pop_handle == `MESM_HANDLE_IBN)
            && (diff_chan_b_enable || remote_sensor_enable);
    endsequence

    a_status_zero_bits: assert property (st_r.status[31:4] == 28'h0000000 && !st_r.status[2])
        else $error("unused status bits not zero");

    a_status_at_pass: assert property ($changed(st_r.status) |-> pass_done_r)
        else $error("status changed outside a pass end");

    a_pass_spacing: assert property (pass_done_r |=> !pass_done_r [*8])
        else $error("pass pulses too close together");

    a_cfg_write_lands: assert property (s_cfg_write |=> st_r.cfg == $past(host_wdata))
        else $error("configuration write lost");

    a_va_placement: assert property (drain && !pop_remote && pop_handle == `MESM_HANDLE_VA
        |=> st_r.raw[`MESM_SLOT_VA] == $past(pop_value))
        else $error("voltage A sample not stored at word 10");

    a_loc3_untouched: assert property (s_drop_b_neg |=> $stable(st_r.raw[`MESM_SLOT_IBN]))
        else $error("word 3 disturbed in differential or remote mode");

    a_remote_to_two: assert property (drain && pop_remote && remote_sensor_enable
        ##0 s_pop_to(`MESM_SLOT_IB) |=> st_r.raw[`MESM_SLOT_IB] == $past(pop_value))
        else $error("remote sample not stored at word 2");

    a_diff_a_merge: assert property (drain && diff_chan_a_enable && !pop_remote
        && pop_handle == `MESM_HANDLE_IAN |=> $stable(st_r.raw[`MESM_SLOT_IAN]))
        else $error("word 1 written in channel A differential mode");

    a_sag_a_timing: assert property ($rose(st_r.status[`MESM_ST_SAG_A_BIT]) |-> pass_done_r
        && st_r.sag[0])
        else $error("voltage A sag flag rose outside a pass");

    a_sag_b_timing: assert property ($rose(st_r.status[`MESM_ST_SAG_B_BIT]) |-> pass_done_r
        && st_r.sag[1])
        else $error("voltage B sag flag rose outside a pass");

    a_aux_follows_sag: assert property (aux_pulse_output_r |-> $past(st_r.cfg[`MESM_CFG_SAG_PULSE_BIT])
        && ($past(st_r.sag) != 2'b00))
        else $error("aux pulse without an enabled sag");

    a_read_status: assert property (host_rd && host_addr == `MESM_ADDR_STATUS
        |=> host_rdata_r == $past(st_r.status))
        else $error("status read returned wrong word");

    a_ia_placement: assert property (drain && !pop_remote && pop_handle == `MESM_HANDLE_IAP
        |=> st_r.raw[`MESM_SLOT_IA] == $past(pop_value))
        else $error("word 0 not written");

    a_vb_placement: assert property (drain && !pop_remote && pop_handle == `MESM_HANDLE_VB
        |=> st_r.raw[`MESM_SLOT_VB] == $past(pop_value))
        else $error("word 9 not written");

    a_word_two_write: assert property (s_pop_to(`MESM_SLOT_IB)
        |=> st_r.raw[`MESM_SLOT_IB] == $past(pop_value))
        else $error("word 2 not written");

    a_ibn_single: assert property (drain && !pop_remote && !remote_sensor_enable && !diff_chan_b_enable
        && pop_handle == `MESM_HANDLE_IBN |=> st_r.raw[`MESM_SLOT_IBN] == $past(pop_value))
        else $error("word 3 not written");

    a_handle_diff_b: assert property (!remote_sensor_enable && diff_chan_b_enable
        |=> input_selector_handle_r == `MESM_HANDLE_IBP && input_selector_handle_ok_r)
        else $error("channel B handle not 2");

    a_handle_undef: assert property (remote_sensor_enable |=> !input_selector_handle_ok_r)
        else $error("channel B handle still valid");

    a_sag_a_clear: assert property (pass_end && mag(st_r.raw[`MESM_SLOT_VA]) > st_r.thr
        |=> !st_r.status[`MESM_ST_SAG_A_BIT])
        else $error("sag A not cleared");

    a_sag_a_hold: assert property (pass_end && st_r.sag[0] && mag(st_r.raw[`MESM_SLOT_VA]) <= st_r.thr
        |=> st_r.status[`MESM_ST_SAG_A_BIT])
        else $error("sag A dropped early");

    a_sag_b_clear: assert property (pass_end && mag(st_r.raw[`MESM_SLOT_VB]) > st_r.thr
        |=> !st_r.status[`MESM_ST_SAG_B_BIT])
        else $error("sag B not cleared");

    a_f0_sign: assert property (pass_end && !st_r.cfg[`MESM_CFG_ZERO_CROSS_PHASE_SELECT_LSB]
        |=> st_r.status[`MESM_ST_F0_BIT] == !$past(st_r.raw[`MESM_SLOT_VA][31]))
        else $error("square wave bit wrong");

    a_pass_pulse: assert property (pass_end |=> pass_done_r)
        else $error("pass end without pulse");
endmodule
`default_nettype wire

/* mesm_host_model.sv */
// Host processor model that reaches the engine words over the word port.
// Assumes the engine takes a strobe at a rising edge and answers one cycle later.
`timescale 1ns/10ps
`default_nettype none
module mesm_host_model (
    input wire logic clk, // Engine clock
    output logic [7:0] host_addr, // Engine word address
    output logic host_wr, // Write strobe
    output logic host_rd, // Read strobe
    output logic [31:0] host_wdata, // Write data
    input wire logic [31:0] host_rdata_r // Read data from engine
);
    initial
    begin
        host_addr = 8'hff;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 32'h00000000;
    end

    // Configuration and threshold are loaded through this one path
    task automatic write_word(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge clk);
        host_wr <= 1'b0;
        // Released data shows the inverse so a stale value cannot pass as live
        host_wdata <= ~d;
    endtask

    task automatic read_word(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge clk);
        host_rd <= 1'b0;
        #1;
        d = host_rdata_r;
    endtask

    // Holding a read on a raw word stalls the sample drain, used to fill the FIFO
    task automatic hold_read(input logic [7:0] a, input int n);
        @(posedge clk);
        host_addr <= a;
        host_rd <= 1'b1;
        repeat (n) @(posedge clk);
        host_rd <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* mesm_engine_tb.sv */
// Self-checking bench for the engine sample map, status and configuration words.
// Assumes a short pass length so that sag counts finish in a few hundred cycles.
`timescale 1ns/10ps
`default_nettype none
module mesm_engine_tb;
    localparam int PASS = 20;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic diff_chan_a_enable = 1'b0;
    logic diff_chan_b_enable = 1'b0;
    logic remote_sensor_enable = 1'b0;
    logic sample_valid = 1'b0;
    logic [3:0] sample_handle = 4'h0;
    logic sample_remote = 1'b0;
    logic [31:0] sample_data = 32'h00000000;
    wire logic sample_ready;
    wire logic [7:0] host_addr;
    wire logic host_wr;
    wire logic host_rd;
    wire logic [31:0] host_wdata;
    wire logic [31:0] host_rdata_r;
    wire logic pass_done_r;
    wire logic aux_pulse_output_r;
    wire logic [3:0] input_selector_handle_r;
    wire logic input_selector_handle_ok_r;
    int n_fail = 0;
    int cmp_count = 0;

    always #2 clk = ~clk;

    mesm_engine #(.REMOTE_CODE(1'b0), .PASS_CYCLES(PASS), .FIFO_DEPTH(32)) mesm_engine_inst (
        .clk(clk), .rstn(rstn), .diff_chan_a_enable(diff_chan_a_enable),
        .diff_chan_b_enable(diff_chan_b_enable), .remote_sensor_enable(remote_sensor_enable),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_handle(sample_handle),
        .sample_remote(sample_remote), .sample_data(sample_data), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata_r(host_rdata_r),
        .pass_done_r(pass_done_r), .aux_pulse_output_r(aux_pulse_output_r),
        .input_selector_handle_r(input_selector_handle_r),
        .input_selector_handle_ok_r(input_selector_handle_ok_r));

    mesm_host_model mesm_host_model_inst (
        .clk(clk), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
        .host_wdata(host_wdata), .host_rdata_r(host_rdata_r));

    task automatic wrap_up();
        $display("Counts: %0d compared, %0d mismatched", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic timeout(input string what);
        n_fail++;
        $display("MISMATCH %s expected completion seen timeout", what);
        wrap_up();
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        mesm_host_model_inst.read_word(a, v);
        check(what, exp, v);
    endtask

    task automatic send(input logic [3:0] h, input logic rm, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clk);
        sample_handle <= h;
        sample_remote <= rm;
        sample_data <= d;
        sample_valid <= 1'b1;
        @(posedge clk);
        while (sample_ready !== 1'b1 && i < 100)
        begin
            @(posedge clk);
            i++;
        end
        if (i >= 100)
            timeout("sample handshake");
        sample_valid <= 1'b0;
        sample_data <= ~d;
        repeat (3) @(posedge clk);
    endtask

    // Returns one edge after the pass-done pulse, with the new status in place
    task automatic wait_pass(output int n);
        n = 1;
        @(posedge clk);
        while (pass_done_r !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 200)
            timeout("pass done");
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        timeout("whole run");
    end

    initial
    begin
        int n;
        int acc;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rchk(8'h20, 32'h0030db00, "config reset");
        rchk(8'h80, 32'h00000000, "status reset");
        rchk(8'h40, 32'h00000000, "unmapped read");
        mesm_host_model_inst.write_word(8'h80, 32'hffffffff);
        rchk(8'h80, 32'h00000000, "status write ignored");
        $display("Test reset values done");

        send(4'ha, 1'b0, 32'h0000a00a);
        send(4'h9, 1'b0, 32'h00009009);
        send(4'h1, 1'b0, 32'h00000011);
        rchk(8'h0a, 32'h0000a00a, "voltage a word");
        rchk(8'h09, 32'h00009009, "voltage b word");
        rchk(8'h01, 32'h00000011, "word 1 single ended");
        diff_chan_a_enable <= 1'b1;
        send(4'h0, 1'b0, 32'h000000a0);
        send(4'h1, 1'b0, 32'h000000a1);
        rchk(8'h00, 32'h000000a0, "diff a word 0");
        rchk(8'h01, 32'h00000011, "diff a word 1 kept");
        $display("Test channel A and voltage placement done");

        send(4'h3, 1'b0, 32'h00000033);
        rchk(8'h03, 32'h00000033, "word 3 single ended");
        check("handle single ended", 32'h3, {28'h0, input_selector_handle_r});
        diff_chan_b_enable <= 1'b1;
        send(4'h2, 1'b0, 32'h000000b2);
        send(4'h3, 1'b0, 32'h000000b3);
        rchk(8'h02, 32'h000000b2, "diff b word 2");
        rchk(8'h03, 32'h00000033, "diff b word 3 kept");
        check("handle diff b", 32'h12, {27'h0, input_selector_handle_ok_r, input_selector_handle_r});
        remote_sensor_enable <= 1'b1;
        send(4'h2, 1'b1, 32'h000000c2);
        send(4'h3, 1'b0, 32'h000000c3);
        send(4'h2, 1'b0, 32'h000000d2);
        rchk(8'h02, 32'h000000c2, "remote word 2");
        rchk(8'h03, 32'h00000033, "remote word 3 kept");
        check("handle undefined", 32'h0, {31'h0, input_selector_handle_ok_r});
        $display("Test channel B placement done");

        wait_pass(n);
        wait_pass(n);
        check("pass period", PASS, n);
        mesm_host_model_inst.write_word(8'h24, 32'h00000064);
        mesm_host_model_inst.write_word(8'h20, 32'h00100300);
        rchk(8'h20, 32'h00100300, "config readback");
        wait_pass(n);
        send(4'ha, 1'b0, 32'h00000005);
        send(4'h9, 1'b0, 32'h000001f4);
        wait_pass(n);
        wait_pass(n);
        rchk(8'h80, 32'h00000008, "sag a short of count");
        wait_pass(n);
        rchk(8'h80, 32'h00000009, "sag a set");
        check("aux on sag", 32'h1, {31'h0, aux_pulse_output_r});
        send(4'ha, 1'b0, 32'hfffffe0c);
        wait_pass(n);
        wait_pass(n);
        rchk(8'h80, 32'h00000000, "sag a cleared, f0 low");
        check("aux off", 32'h0, {31'h0, aux_pulse_output_r});
        mesm_host_model_inst.write_word(8'h20, 32'h00000340);
        wait_pass(n);
        send(4'ha, 1'b0, 32'h000000c8);
        send(4'h9, 1'b0, 32'hfffffffd);
        wait_pass(n);
        wait_pass(n);
        rchk(8'h80, 32'h00000000, "sag b short, f0 from b");
        wait_pass(n);
        rchk(8'h80, 32'h00000002, "sag b set");
        check("aux masked", 32'h0, {31'h0, aux_pulse_output_r});
        $display("Test status and sag done");

        acc = 0;
        fork
            mesm_host_model_inst.hold_read(8'h00, 90);
            begin
                repeat (4) @(posedge clk);
                sample_handle <= 4'ha;
                sample_remote <= 1'b0;
                sample_data <= 32'h00000100;
                sample_valid <= 1'b1;
                for (int k = 0; k < 70; k++)
                begin
                    @(posedge clk);
                    if (sample_valid && sample_ready === 1'b1)
                    begin
                        acc++;
                        sample_data <= 32'h00000100 + acc;
                    end
                end
                check("fifo accepted", 32'd32, acc);
                check("fifo full ready", 32'h0, {31'h0, sample_ready});
                sample_valid <= 1'b0;
            end
        join
        repeat (50) @(posedge clk);
        rchk(8'h0a, 32'h0000011f, "last drained sample");
        $display("Test fifo fill and drain done");
        wrap_up();
    end
endmodule
`default_nettype wire
